// ### hdl/fucd_top.sv
// Format command block decoder with an AXI4-Lite register port.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module fucd_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic format_active
);
  if (ADDR_W < 8)
  begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  typedef enum logic [1:0] {S_IDLE, S_FORMAT, S_DONE} fucd_state_t;

  logic [31:0] cdb0_reg;
  logic [31:0] cdb1_reg;
  logic [31:0] param_reg;
  logic [15:0] modesel_len_reg;
  logic modesel_seen_reg;
  logic [15:0] cur_len_reg;
  logic [15:0] fmt_len_reg;
  fucd_pkg::fucd_result_t result_reg;
  fucd_pkg::fucd_result_t result_next;
  fucd_pkg::fucd_action_t action_reg;
  fucd_pkg::fucd_action_t action_next;
  fucd_pkg::fucd_opts_t opts_reg;
  fucd_pkg::fucd_opts_t opts_next;
  fucd_state_t state_reg;
  logic issue;
  logic finish;
  logic finish_ok;
  logic accept_next;

  // Write channel: address and data may arrive in either order.
  logic [ADDR_W-1:0] awaddr_reg;
  logic aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_have_reg;
  logic do_write;
  logic [7:0] waddr;
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign waddr = awaddr_reg[7:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
    begin
      aw_have_reg <= 1'b0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_have_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
    begin
      w_have_reg <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_have_reg && !s_axi_bvalid;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  logic wr_known;
  assign wr_known = (waddr == fucd_pkg::A_CDB0) || (waddr == fucd_pkg::A_CDB1)
    || (waddr == fucd_pkg::A_PARAM) || (waddr == fucd_pkg::A_MODESEL)
    || (waddr == fucd_pkg::A_CTRL) || (waddr == fucd_pkg::A_RESULT)
    || (waddr == fucd_pkg::A_ACTION) || (waddr == fucd_pkg::A_STATE);
  assign issue = do_write && (waddr == fucd_pkg::A_CTRL) && wstrb_reg[0] && wdata_reg[0];
  assign finish = do_write && (waddr == fucd_pkg::A_CTRL) && wstrb_reg[0] && wdata_reg[1]
    && (state_reg == S_FORMAT);
  assign finish_ok = !wdata_reg[2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fucd_pkg::RESP_OK;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? fucd_pkg::RESP_OK : fucd_pkg::RESP_DECERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Command block words; the block is six bytes, byte 0 in the top lane of word 0.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cdb0_reg <= '0;
      cdb1_reg <= '0;
      param_reg <= '0;
    end
    else if (do_write)
    begin
      if (waddr == fucd_pkg::A_CDB0)
      begin
        cdb0_reg <= merge(cdb0_reg, wdata_reg, wstrb_reg);
      end
      if (waddr == fucd_pkg::A_CDB1)
      begin
        cdb1_reg <= merge(cdb1_reg, wdata_reg, wstrb_reg);
      end
      if (waddr == fucd_pkg::A_PARAM)
      begin
        param_reg <= merge(param_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  // The block length is latched from mode select; a reset forgets that one arrived.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      modesel_len_reg <= fucd_pkg::BLK_RESET;
      modesel_seen_reg <= 1'b0;
    end
    else if (do_write && waddr == fucd_pkg::A_MODESEL && wstrb_reg[1:0] == 2'b11)
    begin
      modesel_len_reg <= wdata_reg[15:0];
      modesel_seen_reg <= 1'b1;
    end
  end

  // Field extraction; byte n (n < 4) of the block sits at bits [31-8n -: 8] of word 0, byte n+4 at the same bits of word 1.
  logic [7:0] b_op;
  logic [7:0] b_1;
  logic [7:0] b_4;
  logic [7:0] b_ctrl;
  logic [1:0] protection_format_select;
  logic parameter_data_follows;
  logic replace_grown_list;
  logic [2:0] defect_list_format;
  logic [1:0] fast_format_code;
  logic [2:0] prot_usage;
  logic [15:0] defect_list_len;
  logic [15:0] target_len;
  logic size_compatible;
  assign b_op = cdb0_reg[31:24];
  assign b_1 = cdb0_reg[23:16];
  assign b_4 = cdb1_reg[31:24];
  // Last block byte is the control byte; vendor bits, flag and link are not consulted.
  assign b_ctrl = cdb1_reg[23:16];
  assign protection_format_select = b_1[7:6];
  assign parameter_data_follows = b_1[4];
  assign replace_grown_list = b_1[3];
  assign defect_list_format = b_1[2:0];
  assign fast_format_code = b_4[1:0];
  // Header word: byte 0 usage, byte 1 options, bytes 2..3 list length high first.
  assign prot_usage = param_reg[26:24];
  assign defect_list_len = {param_reg[15:8], param_reg[7:0]};
  assign target_len = modesel_seen_reg ? modesel_len_reg : cur_len_reg;
  assign size_compatible = (target_len == cur_len_reg)
    || ((target_len == fucd_pkg::BLK_512) && (cur_len_reg == fucd_pkg::BLK_4096))
    || ((target_len == fucd_pkg::BLK_4096) && (cur_len_reg == fucd_pkg::BLK_512));

  // Checks are in priority order: block field errors first, then parameter list.
  always_comb
  begin
    result_next = '{fucd_pkg::ST_GOOD, fucd_pkg::SK_NONE, fucd_pkg::ASC_NONE,
                    fucd_pkg::ASCQ_NONE};
    action_next = '0;
    opts_next = '{fucd_pkg::DEF_PRIMARY_DISABLE, fucd_pkg::DEF_CERT_DISABLE,
                  fucd_pkg::DEF_STOP_ON_ERR, fucd_pkg::DEF_INIT_PATTERN,
                  fucd_pkg::DEF_SAVE_DISABLE, fucd_pkg::DEF_IMMED};
    accept_next = 1'b0;
    if (state_reg == S_FORMAT)
    begin
      if (b_op == fucd_pkg::OP_REQ_SENSE)
      begin
        result_next = '{fucd_pkg::ST_GOOD, fucd_pkg::SK_NOT_READY, fucd_pkg::ASC_FMT_PROG,
                        fucd_pkg::ASCQ_FMT_PROG};
      end
      else if (b_op != fucd_pkg::OP_INQUIRY)
      begin
        result_next.status = fucd_pkg::ST_CHECK;
      end
    end
    else if (b_op == fucd_pkg::OP_FORMAT)
    begin
      result_next.status = fucd_pkg::ST_CHECK;
      result_next.key = fucd_pkg::SK_ILLEGAL;
      result_next.asc = fucd_pkg::ASC_CDB;
      if (!parameter_data_follows && defect_list_format != fucd_pkg::DLF_BLOCK)
      begin
        result_next.ascq = fucd_pkg::ASCQ_NONE;
      end
      else if (protection_format_select == fucd_pkg::PFS_BAD)
      begin
        result_next.ascq = fucd_pkg::ASCQ_NONE;
      end
      else if (fast_format_code == 2'h3)
      begin
        result_next.ascq = fucd_pkg::ASCQ_NONE;
      end
      else if (parameter_data_follows && defect_list_format != fucd_pkg::DLF_BFI
               && defect_list_format != fucd_pkg::DLF_PHYS)
      begin
        result_next.ascq = fucd_pkg::ASCQ_NONE;
      end
      else if (fast_format_code == fucd_pkg::FF_SIZE && (replace_grown_list
               || (parameter_data_follows && (!param_reg[21] || defect_list_len != '0))))
      begin
        result_next.ascq = fucd_pkg::ASCQ_FAST_COMBO;
      end
      else if (fast_format_code == fucd_pkg::FF_SIZE && !size_compatible)
      begin
        result_next.ascq = fucd_pkg::ASCQ_NONE;
      end
      else if (protection_format_select != 2'h0 && parameter_data_follows
               && prot_usage != fucd_pkg::PFU_ZERO)
      begin
        result_next.asc = fucd_pkg::ASC_PARAM;
      end
      else
      begin
        result_next = '{fucd_pkg::ST_GOOD, fucd_pkg::SK_NONE, fucd_pkg::ASC_NONE,
                        fucd_pkg::ASCQ_NONE};
        accept_next = 1'b1;
        if (parameter_data_follows)
        begin
          opts_next = {param_reg[22:18], param_reg[17]};
        end
        action_next.prot_type = parameter_data_follows ? protection_format_select : 2'h0;
        action_next.discard_grown = replace_grown_list;
        action_next.merge_grown = !replace_grown_list;
        action_next.size_only = (fast_format_code == fucd_pkg::FF_SIZE);
        action_next.mark_partial_hard = (fast_format_code == fucd_pkg::FF_SIZE)
          && (cur_len_reg == fucd_pkg::BLK_512);
        action_next.defect_mgmt = (fast_format_code != fucd_pkg::FF_SIZE);
        action_next.init_media = (fast_format_code == fucd_pkg::FF_FULL);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= S_IDLE;
      result_reg <= '0;
      action_reg <= '0;
      opts_reg <= '0;
      fmt_len_reg <= fucd_pkg::BLK_RESET;
    end
    else if (issue)
    begin
      result_reg <= result_next;
      if (accept_next)
      begin
        state_reg <= S_FORMAT;
        action_reg <= action_next;
        opts_reg <= opts_next;
        fmt_len_reg <= target_len;
      end
    end
    else if (finish)
    begin
      state_reg <= S_DONE;
    end
  end

  // Length kept only after success; a failed format leaves the old length.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_len_reg <= fucd_pkg::BLK_RESET;
    end
    else if (finish && finish_ok)
    begin
      cur_len_reg <= fmt_len_reg;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      format_active <= 1'b0;
    end
    else
    begin
      format_active <= (issue && accept_next) || (state_reg == S_FORMAT && (issue || !finish));
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= fucd_pkg::RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= fucd_pkg::RESP_OK;
      case (s_axi_araddr[7:0])
        fucd_pkg::A_CDB0: s_axi_rdata <= cdb0_reg;
        fucd_pkg::A_CDB1: s_axi_rdata <= cdb1_reg;
        fucd_pkg::A_PARAM: s_axi_rdata <= param_reg;
        fucd_pkg::A_MODESEL: s_axi_rdata <= {15'h0000, modesel_seen_reg, modesel_len_reg};
        fucd_pkg::A_CTRL: s_axi_rdata <= {24'h00_0000, b_ctrl};
        fucd_pkg::A_RESULT: s_axi_rdata <= {4'h0, result_reg};
        fucd_pkg::A_ACTION: s_axi_rdata <= {10'h000, opts_reg, action_reg, 8'h00};
        fucd_pkg::A_STATE: s_axi_rdata <= {14'h0000, state_reg, cur_len_reg};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= fucd_pkg::RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid)
    begin
      s_axi_rvalid <= !s_axi_rready;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : fucd_top

// ### hdl/fucd_pkg.sv
// Package with constants, types and the register map of the format command decoder.
package fucd_pkg;
  localparam logic [7:0] OP_FORMAT = 8'h04;
  localparam logic [7:0] OP_REQ_SENSE = 8'h03;
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  localparam logic [2:0] DLF_BLOCK = 3'h0;
  localparam logic [2:0] DLF_BFI = 3'h4;
  localparam logic [2:0] DLF_PHYS = 3'h5;
  localparam logic [1:0] FF_FULL = 2'h0;
  localparam logic [1:0] FF_SIZE = 2'h1;
  localparam logic [1:0] FF_NOINIT = 2'h2;
  localparam logic [1:0] PFS_BAD = 2'h1;
  localparam logic [1:0] PFS_T1 = 2'h2;
  localparam logic [1:0] PFS_T2 = 2'h3;
  localparam logic [2:0] PFU_ZERO = 3'h0;
  // Status and sense codes.
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_NOT_READY = 4'h2;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_CDB = 8'h24;
  localparam logic [7:0] ASC_PARAM = 8'h26;
  localparam logic [7:0] ASC_FMT_PROG = 8'h04;
  localparam logic [7:0] ASCQ_NONE = 8'h00;
  localparam logic [7:0] ASCQ_FMT_PROG = 8'h04;
  localparam logic [7:0] ASCQ_FAST_COMBO = 8'h09;
  // Default option bits when no parameter list follows.
  localparam logic DEF_PRIMARY_DISABLE = 1'b0;
  localparam logic DEF_CERT_DISABLE = 1'b1;
  localparam logic DEF_STOP_ON_ERR = 1'b1;
  localparam logic DEF_INIT_PATTERN = 1'b0;
  localparam logic DEF_SAVE_DISABLE = 1'b0;
  localparam logic DEF_IMMED = 1'b0;
  localparam logic [15:0] BLK_512 = 16'h0200;
  localparam logic [15:0] BLK_4096 = 16'h1000;
  localparam logic [15:0] BLK_RESET = 16'h0200;
  // AXI4-Lite register byte offsets.
  localparam logic [7:0] A_CDB0 = 8'h00;
  localparam logic [7:0] A_CDB1 = 8'h04;
  localparam logic [7:0] A_PARAM = 8'h08;
  localparam logic [7:0] A_MODESEL = 8'h0C;
  localparam logic [7:0] A_CTRL = 8'h10;
  localparam logic [7:0] A_RESULT = 8'h14;
  localparam logic [7:0] A_ACTION = 8'h18;
  localparam logic [7:0] A_STATE = 8'h1C;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [7:0] status;
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } fucd_result_t;

  typedef struct packed {
    logic primary_list_disable;
    logic certification_disable;
    logic stop_on_list_error;
    logic init_pattern_present;
    logic save_disable;
    logic immediate;
  } fucd_opts_t;

  typedef struct packed {
    logic discard_grown;
    logic merge_grown;
    logic defect_mgmt;
    logic init_media;
    logic size_only;
    logic mark_partial_hard;
    logic [1:0] prot_type;
  } fucd_action_t;
endpackage : fucd_pkg

// ### verif/fucd_chk.sv
// Port-level assertions for the format command decoder.
`timescale 1ns/10ps
module fucd_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic format_active
);
  logic wtake;
  assign wtake = s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early.");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read data dropped early.");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data late.");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address taken while data pending.");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while response pending.");
  chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && wtake |->
    ##[1:3] s_axi_bvalid)
    else $error("Write response late.");
  chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid &&
    !s_axi_rvalid && !s_axi_awready && !s_axi_arready && !format_active)
    else $error("Outputs busy after reset.");
  // A format only starts or ends through a register write, never by itself.
  chk_active_cause: assert property ($past(aresetn) && $changed(format_active) |->
    $past(wtake) || $past(wtake, 2) || $past(wtake, 3) || $past(wtake, 4))
    else $error("Format state changed without a write.");
endmodule : fucd_chk

bind fucd_top fucd_chk #(.ADDR_W(ADDR_W)) fucd_chk_inst (.*);

// ### verif/fucd_host.sv
// Host initiator model issuing register cycles to the decoder.
`timescale 1ns/10ps
module fucd_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int stall = 0;
  initial
  begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // Released payloads flip so a stale value can never pass as fresh.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
    output bit t);
    bit aw;
    bit w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((aw || w) && n < 50)
    begin
      @(posedge aclk);
      n++;
      if (aw && s_axi_awready)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w && s_axi_wready)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    repeat (stall) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_bvalid && n++ < 100);
    r = s_axi_bresp;
    t = !s_axi_bvalid;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
    output bit t);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready && n++ < 50);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (stall) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_rvalid && n++ < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    t = !s_axi_rvalid;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : fucd_host

// ### verif/format_unit_cdb_decoder_test.sv
// Self-checking bench for the format command decoder.
`timescale 1ns/10ps
module format_unit_cdb_decoder_test;
  localparam logic [31:0] GOOD = 32'h0000_0000;
  localparam logic [31:0] BAD_CDB = {4'h0, fucd_pkg::ST_CHECK, fucd_pkg::SK_ILLEGAL,
    fucd_pkg::ASC_CDB, fucd_pkg::ASCQ_NONE};
  localparam logic [31:0] COMBO = {4'h0, fucd_pkg::ST_CHECK, fucd_pkg::SK_ILLEGAL,
    fucd_pkg::ASC_CDB, fucd_pkg::ASCQ_FAST_COMBO};
  localparam logic [31:0] BAD_PAR = {4'h0, fucd_pkg::ST_CHECK, fucd_pkg::SK_ILLEGAL,
    fucd_pkg::ASC_PARAM, fucd_pkg::ASCQ_NONE};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, format_active;
  int n_mismatch = 0;
  int tests_run = 0;
  always #2 aclk = ~aclk;
  fucd_top #(.ADDR_W(8)) fucd_top_inst (.*);
  fucd_host fucd_host_inst (.*);
  task automatic print_verdict;
    $display("Compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic hang;
    n_mismatch++;
    print_verdict();
  endtask : hang
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bit t;
    fucd_host_inst.wr(a, d, last_resp, t);
    if (t)
      hang();
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    bit t;
    fucd_host_inst.rd(a, d, last_resp, t);
    if (t)
      hang();
  endtask : rreg
  // Control byte always carries flag and link set, which must change nothing.
  task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b4,
    output logic [31:0] res);
    wreg(fucd_pkg::A_CDB0, {b0, b1, 16'h0000});
    wreg(fucd_pkg::A_CDB1, {b4, 8'h03, 16'h0000});
    wreg(fucd_pkg::A_CTRL, 32'h0000_0001);
    rreg(fucd_pkg::A_RESULT, res);
  endtask : issue
  task automatic t_reset;
    logic [31:0] d;
    rreg(fucd_pkg::A_MODESEL, d);
    check(d, {16'h0000, fucd_pkg::BLK_RESET});
    rreg(8'h20, d);
    check(32'(last_resp), 32'(fucd_pkg::RESP_DECERR));
    wreg(8'h24, 32'h0000_0000);
    check(32'(last_resp), 32'(fucd_pkg::RESP_DECERR));
  endtask : t_reset
  task automatic t_default;
    logic [31:0] d;
    issue(fucd_pkg::OP_FORMAT, 8'h00, 8'h00, d);
    check(d, GOOD);
    check(32'(format_active), 32'h1);
    rreg(fucd_pkg::A_ACTION, d);
    check(32'(d[21:16]), 32'h18);
    check(32'(d[13:8]), 32'h30);
    issue(fucd_pkg::OP_REQ_SENSE, 8'h00, 8'h00, d);
    check(d, {4'h0, fucd_pkg::ST_GOOD, fucd_pkg::SK_NOT_READY, fucd_pkg::ASC_FMT_PROG,
      fucd_pkg::ASCQ_FMT_PROG});
    issue(fucd_pkg::OP_INQUIRY, 8'h00, 8'h00, d);
    check(32'(d[27:20]), 32'(fucd_pkg::ST_GOOD));
    issue(8'h28, 8'h00, 8'h00, d);
    check(32'(d[27:20]), 32'(fucd_pkg::ST_CHECK));
    wreg(fucd_pkg::A_CTRL, 32'h0000_0002);
    rreg(fucd_pkg::A_STATE, d);
    check(d, 32'h0002_0200);
    check(32'(format_active), 32'h0);
  endtask : t_default
  task automatic t_errors;
    logic [15:0] cmd[9] = '{16'h0400, 16'h4000, 16'h0003, 16'h1000, 16'h1600, 16'h1C01,
      16'h1401, 16'h1401, 16'hD400};
    logic [31:0] pr[9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0020_0000, 32'h0,
      32'h0020_0100, 32'h0120_0000};
    logic [31:0] ex[9] = '{BAD_CDB, BAD_CDB, BAD_CDB, BAD_CDB, BAD_CDB, COMBO, COMBO, COMBO,
      BAD_PAR};
    logic [31:0] d;
    for (int i = 0; i < 9; i++)
    begin
      wreg(fucd_pkg::A_PARAM, pr[i]);
      issue(fucd_pkg::OP_FORMAT, cmd[i][15:8], cmd[i][7:0], d);
      check(d, ex[i]);
      check(32'(format_active), 32'h0);
    end
  endtask : t_errors
  // Every pass here ends in a failed format, so the stored length must not move.
  task automatic t_lists;
    logic [31:0] d;
    for (int i = 0; i < 4; i++)
    begin
      wreg(fucd_pkg::A_PARAM, 32'h0020_0004);
      issue(fucd_pkg::OP_FORMAT, {3'b000, 1'b1, i[0], 2'b10, i[1]}, 8'h00, d);
      check(d, GOOD);
      rreg(fucd_pkg::A_ACTION, d);
      check(32'(d[15:12]), {28'h0, i[0], !i[0], 2'b11});
      wreg(fucd_pkg::A_CTRL, 32'h0000_0006);
    end
    issue(fucd_pkg::OP_FORMAT, 8'h00, 8'h02, d);
    rreg(fucd_pkg::A_ACTION, d);
    check(32'(d[13:12]), 32'h2);
    wreg(fucd_pkg::A_CTRL, 32'h0000_0006);
    rreg(fucd_pkg::A_STATE, d);
    check(32'(d[15:0]), 32'h0200);
  endtask : t_lists
  task automatic t_size;
    logic [31:0] d;
    issue(fucd_pkg::OP_FORMAT, 8'h08, 8'h01, d);
    check(d, COMBO);
    issue(fucd_pkg::OP_FORMAT, 8'h08, 8'h00, d);
    check(d, GOOD);
    rreg(fucd_pkg::A_ACTION, d);
    check(32'(d[15]), 32'h1);
    wreg(fucd_pkg::A_CTRL, 32'h0000_0002);
    wreg(fucd_pkg::A_MODESEL, 32'h0000_1000);
    rreg(fucd_pkg::A_MODESEL, d);
    check(d, 32'h0001_1000);
    issue(fucd_pkg::OP_FORMAT, 8'h00, 8'h01, d);
    check(d, GOOD);
    rreg(fucd_pkg::A_ACTION, d);
    check(32'(d[11:10]), 32'h3);
    wreg(fucd_pkg::A_CTRL, 32'h0000_0002);
    rreg(fucd_pkg::A_STATE, d);
    check(d, 32'h0002_1000);
    wreg(fucd_pkg::A_MODESEL, 32'h0000_0208);
    issue(fucd_pkg::OP_FORMAT, 8'h00, 8'h01, d);
    check(d, BAD_CDB);
    issue(fucd_pkg::OP_FORMAT, 8'h00, 8'h00, d);
    wreg(fucd_pkg::A_CTRL, 32'h0000_0002);
    rreg(fucd_pkg::A_STATE, d);
    check(d, 32'h0002_0208);
  endtask : t_size
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_default();
    t_errors();
    fucd_host_inst.stall = 3;
    t_lists();
    fucd_host_inst.stall = 0;
    t_size();
    print_verdict();
  end
endmodule : format_unit_cdb_decoder_test
